/* File: long_exec_defines.svh */
// Constants for the extended-address skip, table-read and XOR execution unit.
// Assumes an 8-bit data path, a 256-byte data space and a 16-bit program word.
// Overview of operation
// - The byte-test-with-copy skip loads the addressed data byte into the accumulator first.
// - That copy skip then skips the next instruction when the byte is zero, else goes on.
// - The bit test skips the next instruction when the selected bit is zero, else goes on.
// - A met skip inserts one dummy cycle, so the skipping instruction takes two cycles.
// - The current-page table read fetches the word at the pointer low byte in the current page.
// - The last-page table read fetches the word at the pointer low byte in the last page.
// - The incrementing table read bumps the pointer low byte, then reads at high and low pointer.
// - The incrementing last-page read bumps the pointer low byte, then reads in the last page.
// - XOR to accumulator puts accumulator XOR data byte in the accumulator, touching only Z.
// - XOR to memory puts accumulator XOR data byte back in the data byte, touching only Z.
`ifndef LONG_EXEC_DEFINES_SVH
`define LONG_EXEC_DEFINES_SVH
`define DATA_DEPTH 256
`define LAST_PAGE 8'hff
`define ACC_RESET 8'h00
`define TBL_RESET 8'h00
`define ZERO_BYTE 8'h00
`endif

/* File: long_exec_pkg.sv */
// Types shared by the execution unit and its testbench.
// Assumes the defines header is compiled alongside.
package long_exec_pkg;
  typedef enum logic [2:0] {
    skip_if_zero_copy_to_acc,
    skip_if_zero_test,
    table_read_current_page,
    table_read_last_page,
    table_read_pre_increment,
    table_read_last_page_pre_increment,
    exclusive_or_to_accumulator,
    exclusive_or_to_memory
  } op_t;

  typedef enum logic [2:0] {st_idle, st_exec, st_fetch, st_store, st_dummy} state_t;

  typedef struct packed {
    state_t state;
    op_t op;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic [7:0] accumulator;
    logic zero_flag;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_latch;
    logic [15:0] prog_addr;
    logic prog_rd;
    logic skip_slot;
    logic done;
    logic ready;
  } core_t;
endpackage

/* File: long_exec_ram.sv */
// Data memory of the execution unit: 256 bytes, asynchronous read, clocked write.
// Assumes a single writer per cycle, chosen by the execution unit.
`timescale 1ns/100ps
`include "long_exec_defines.svh"
module long_exec_ram (
  input wire logic clk,            // Core clock
  input wire logic wr,             // Write strobe
  input wire logic [7:0] waddr,    // Write address
  input wire logic [7:0] wdata,    // Write data
  input wire logic [7:0] raddr,    // Read address
  output logic [7:0] rdata         // Read data, same cycle
);
  logic [7:0] mem [0:`DATA_DEPTH-1];

  // No reset: contents are undefined until software writes them
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

/* File: long_skip_table_xor_exec.sv */
// Execution unit for the extended skip, table-read and XOR instructions.
// Assumes program memory answers prog_rd with prog_word on the following cycle
// and that the core holds pc_page steady while an instruction runs.
`timescale 1ns/100ps
`include "long_exec_defines.svh"
module long_skip_table_xor_exec
  import long_exec_pkg::*;
(
  input wire logic clk,                     // Core clock, 25 MHz
  input wire logic sys_rst,                 // Asynchronous reset, active high
  input wire logic issue,                   // Start an instruction (taken when ready)
  input wire op_t op,                       // Instruction to run
  input wire logic [7:0] mem_addr,          // Data byte address
  input wire logic [2:0] bit_sel,           // Bit index for the bit test
  input wire logic [7:0] pc_page,           // Current program page
  input wire logic [15:0] prog_word,        // Program memory read data
  input wire logic acc_load,                // Load accumulator while idle
  input wire logic [7:0] acc_in,            // Accumulator load value
  input wire logic tp_load,                 // Load table pointer while idle
  input wire logic [7:0] tp_low_in,         // Table pointer low load value
  input wire logic [7:0] tp_high_in,        // Table pointer high load value
  input wire logic ext_wr,                  // Data memory write while idle
  input wire logic [7:0] ext_addr,          // Data memory write address
  input wire logic [7:0] ext_wdata,         // Data memory write data
  output logic ready,                       // Idle, may issue
  output logic done,                        // Instruction finished
  output logic skip_slot,                   // Next fetched instruction is discarded
  output logic [7:0] accumulator,           // Accumulator
  output logic zero_flag,                   // Zero flag
  output logic [7:0] table_pointer_low,     // Table pointer low byte
  output logic [7:0] table_pointer_high,    // Table pointer high byte
  output logic [7:0] table_high_latch,      // Table read high byte
  output logic [15:0] prog_addr,            // Program memory address
  output logic prog_rd                      // Program memory read strobe
);
  core_t r;
  core_t next_r;
  logic ram_wr;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] ptr;
  logic [7:0] xor_val;

  function automatic logic is_zero(input logic [7:0] b);
    return b == `ZERO_BYTE;
  endfunction

  function automatic logic pre_inc(input op_t o);
    return o == table_read_pre_increment || o == table_read_last_page_pre_increment;
  endfunction

  function automatic logic last_page(input op_t o);
    return o == table_read_last_page || o == table_read_last_page_pre_increment;
  endfunction

  long_exec_ram u_ram (
    .clk(clk),
    .wr(ram_wr),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(r.addr),
    .rdata(ram_rdata)
  );

  assign ptr = pre_inc(r.op) ? r.table_pointer_low + 8'h01 : r.table_pointer_low;
  assign xor_val = r.accumulator ^ ram_rdata;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.skip_slot = 1'b0;
    next_r.prog_rd = 1'b0;
    ram_wr = 1'b0;
    ram_waddr = r.addr;
    ram_wdata = `ZERO_BYTE;
    unique case (r.state)
      st_idle: begin
        next_r.ready = 1'b1;
        if (acc_load) begin
          next_r.accumulator = acc_in;
        end
        if (tp_load) begin
          next_r.table_pointer_low = tp_low_in;
          next_r.table_pointer_high = tp_high_in;
        end
        if (ext_wr) begin
          ram_wr = 1'b1;
          ram_waddr = ext_addr;
          ram_wdata = ext_wdata;
        end
        if (issue) begin
          next_r.op = op;
          next_r.addr = mem_addr;
          next_r.bitsel = bit_sel;
          next_r.ready = 1'b0;
          next_r.state = st_exec;
        end
      end
      st_exec: begin
        next_r.state = st_idle;
        next_r.done = 1'b1;
        next_r.ready = 1'b1;
        unique case (r.op)
          skip_if_zero_copy_to_acc: begin
            next_r.accumulator = ram_rdata;
            if (is_zero(ram_rdata)) begin
              next_r.state = st_dummy;
              next_r.skip_slot = 1'b1;
              next_r.done = 1'b0;
              next_r.ready = 1'b0;
            end
          end
          skip_if_zero_test: begin
            if (!ram_rdata[r.bitsel]) begin
              next_r.state = st_dummy;
              next_r.skip_slot = 1'b1;
              next_r.done = 1'b0;
              next_r.ready = 1'b0;
            end
          end
          exclusive_or_to_accumulator: begin
            next_r.accumulator = xor_val;
            next_r.zero_flag = is_zero(xor_val);
          end
          exclusive_or_to_memory: begin
            ram_wr = 1'b1;
            ram_wdata = xor_val;
            next_r.zero_flag = is_zero(xor_val);
          end
          default: begin
            // All four table reads share one fetch path
            next_r.table_pointer_low = ptr;
            if (last_page(r.op)) begin
              next_r.prog_addr = {`LAST_PAGE, ptr};
            end else if (pre_inc(r.op)) begin
              next_r.prog_addr = {r.table_pointer_high, ptr};
            end else begin
              next_r.prog_addr = {pc_page, ptr};
            end
            next_r.prog_rd = 1'b1;
            next_r.state = st_fetch;
            next_r.done = 1'b0;
            next_r.ready = 1'b0;
          end
        endcase
      end
      st_fetch: begin
        next_r.state = st_store;
      end
      st_store: begin
        ram_wr = 1'b1;
        ram_wdata = prog_word[7:0];
        next_r.table_high_latch = prog_word[15:8];
        next_r.state = st_idle;
        next_r.done = 1'b1;
        next_r.ready = 1'b1;
      end
      st_dummy: begin
        // Dummy slot: the fetched instruction is dropped and nothing is written
        next_r.state = st_idle;
        next_r.done = 1'b1;
        next_r.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{state: st_idle, op: skip_if_zero_copy_to_acc, addr: 8'h00, bitsel: 3'h0,
             accumulator: `ACC_RESET, zero_flag: 1'b0, table_pointer_low: `TBL_RESET,
             table_pointer_high: `TBL_RESET, table_high_latch: 8'h00, prog_addr: 16'h0000,
             prog_rd: 1'b0, skip_slot: 1'b0, done: 1'b0, ready: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign ready = r.ready;
  assign done = r.done;
  assign skip_slot = r.skip_slot;
  assign accumulator = r.accumulator;
  assign zero_flag = r.zero_flag;
  assign table_pointer_low = r.table_pointer_low;
  assign table_pointer_high = r.table_pointer_high;
  assign table_high_latch = r.table_high_latch;
  assign prog_addr = r.prog_addr;
  assign prog_rd = r.prog_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic exec_now;
  logic sel_bit;
  assign exec_now = r.state == st_exec;
  assign sel_bit = ram_rdata[r.bitsel];

  sequence dummy_slot;
    skip_slot && !done ##1 done && !skip_slot;
  endsequence

  sequence fetch_then_store;
    prog_rd && r.state == st_fetch ##1 !prog_rd && r.state == st_store;
  endsequence

  chk_copy_load: assert property (exec_now && r.op == skip_if_zero_copy_to_acc
    |=> accumulator == $past(ram_rdata)) else $error("copy skip did not load accumulator");
  chk_copy_skip: assert property (exec_now && r.op == skip_if_zero_copy_to_acc
    |=> skip_slot == is_zero($past(ram_rdata))) else $error("copy skip decision wrong");
  chk_bit_skip: assert property (exec_now && r.op == skip_if_zero_test
    |=> skip_slot == !$past(sel_bit)) else $error("bit test skip decision wrong");
  chk_skip_two_cycles: assert property ((exec_now ##1 skip_slot) |-> dummy_slot)
    else $error("skip did not take exactly one dummy cycle");
  chk_tab_current: assert property (exec_now && r.op == table_read_current_page
    |=> prog_addr == {$past(pc_page), $past(r.table_pointer_low)} ##0 fetch_then_store)
    else $error("current page table address wrong");
  chk_tab_split: assert property (r.state == st_store
    |-> ram_wr && ram_wdata == prog_word[7:0] ##1 table_high_latch == $past(prog_word[15:8]))
    else $error("table word not split into memory and latch");
  chk_tab_last: assert property (exec_now && r.op == table_read_last_page
    |=> prog_addr == {`LAST_PAGE, $past(r.table_pointer_low)})
    else $error("last page table address wrong");
  chk_tab_inc: assert property (exec_now && r.op == table_read_pre_increment
    |=> table_pointer_low == $past(r.table_pointer_low) + 8'h01
        && prog_addr == {$past(r.table_pointer_high), table_pointer_low})
    else $error("incrementing table read address wrong");
  chk_tab_inc_last: assert property (exec_now && r.op == table_read_last_page_pre_increment
    |=> table_pointer_low == $past(r.table_pointer_low) + 8'h01
        && prog_addr == {`LAST_PAGE, table_pointer_low})
    else $error("incrementing last page read address wrong");
  chk_xor_acc: assert property (exec_now && r.op == exclusive_or_to_accumulator
    |=> accumulator == $past(xor_val) && zero_flag == is_zero(accumulator))
    else $error("xor to accumulator wrong");
  chk_xor_mem: assert property (exec_now && r.op == exclusive_or_to_memory
    |-> ram_wr && ram_wdata == xor_val ##1 zero_flag == is_zero($past(xor_val))
        && $stable(accumulator)) else $error("xor to memory wrong");
  chk_dummy_quiet: assert property (r.state == st_dummy
    |-> !ram_wr && !prog_rd ##1 $stable(accumulator) && $stable(zero_flag)
        && $stable(table_pointer_low) && $stable(table_high_latch))
    else $error("state changed during dummy slot");
endmodule

/* File: test_long_skip_table_xor_exec.sv */
// Self-checking bench for the extended skip, table-read and XOR execution unit.
// Assumes the package and defines header are compiled first; the bench plays program memory.
`timescale 1ns/100ps
module test_long_skip_table_xor_exec;
  import long_exec_pkg::*;
  logic clk, sys_rst, issue, acc_load, tp_load, ext_wr;
  op_t op;
  logic [7:0] mem_addr, pc_page, acc_in, tp_low_in, tp_high_in, ext_addr, ext_wdata;
  logic [2:0] bit_sel;
  logic [15:0] prog_word;
  logic ready, done, skip_slot, zero_flag, prog_rd;
  logic [7:0] accumulator, table_pointer_low, table_pointer_high, table_high_latch;
  logic [15:0] prog_addr;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int took;
  int skip_at;
  int rd_seen = 0;

  long_skip_table_xor_exec u_long_skip_table_xor_exec (
    .clk(clk), .sys_rst(sys_rst), .issue(issue), .op(op), .mem_addr(mem_addr),
    .bit_sel(bit_sel), .pc_page(pc_page), .prog_word(prog_word), .acc_load(acc_load),
    .acc_in(acc_in), .tp_load(tp_load), .tp_low_in(tp_low_in), .tp_high_in(tp_high_in),
    .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ready(ready),
    .done(done), .skip_slot(skip_slot), .accumulator(accumulator), .zero_flag(zero_flag),
    .table_pointer_low(table_pointer_low), .table_pointer_high(table_pointer_high),
    .table_high_latch(table_high_latch), .prog_addr(prog_addr), .prog_rd(prog_rd)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Address-dependent word so a wrong page shows up in the low half and a wrong pointer in the high half
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {a[7:0] ^ 8'h5a, a[15:8] ^ 8'h3c};
  endfunction

  // Program memory answers one edge after the read strobe and holds the word
  always @(posedge clk) begin
    if (prog_rd === 1'b1) begin
      prog_word <= pat(prog_addr);
      rd_seen++;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic set_acc(input logic [7:0] v);
    @(posedge clk);
    acc_load <= 1'b1;
    acc_in <= v;
    @(posedge clk);
    acc_load <= 1'b0;
  endtask

  task automatic set_tp(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clk);
    tp_load <= 1'b1;
    tp_low_in <= lo;
    tp_high_in <= hi;
    @(posedge clk);
    tp_load <= 1'b0;
  endtask

  task automatic wr_mem(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ext_wr <= 1'b1;
    ext_addr <= a;
    ext_wdata <= d;
    @(posedge clk);
    ext_wr <= 1'b0;
  endtask

  // Counts edges from the taking edge to done; records where the dummy slot fell
  task automatic run(input op_t o, input logic [7:0] a, input logic [2:0] b);
    @(posedge clk);
    issue <= 1'b1;
    op <= o;
    mem_addr <= a;
    bit_sel <= b;
    @(posedge clk);
    issue <= 1'b0;
    took = 0;
    skip_at = 0;
    while (took < 20) begin
      @(posedge clk);
      #1;
      took++;
      if (skip_slot === 1'b1) skip_at = took;
      if (done === 1'b1) break;
    end
  endtask

  // Memory has no read port: XOR into a cleared accumulator copies the byte out
  task automatic read_mem(input logic [7:0] a, output logic [7:0] v);
    set_acc(8'h00);
    run(exclusive_or_to_accumulator, a, 3'h0);
    v = accumulator;
  endtask

  task automatic t_copy_skip();
    logic [7:0] d[2] = '{8'h00, 8'h80};
    for (int i = 0; i < 2; i++) begin
      wr_mem(8'h10, d[i]);
      set_acc(8'hff);
      run(skip_if_zero_copy_to_acc, 8'h10, 3'h0);
      check("copy acc", 16'(accumulator), 16'(d[i]));
      check("copy cycles", 16'(took), (i == 0) ? 16'h2 : 16'h1);
      check("copy slot", 16'(skip_at), (i == 0) ? 16'h1 : 16'h0);
    end
  endtask

  task automatic t_bit_test();
    wr_mem(8'h12, 8'ha5);
    set_acc(8'h77);
    for (int i = 0; i < 8; i++) begin
      run(skip_if_zero_test, 8'h12, 3'(i));
      check("bit cycles", 16'(took), ((8'ha5 >> i) & 1) ? 16'h1 : 16'h2);
      check("bit slot", 16'(skip_at), ((8'ha5 >> i) & 1) ? 16'h0 : 16'h1);
      check("bit acc", 16'(accumulator), 16'h77);
    end
  endtask

  task automatic t_table();
    op_t ops[4] = '{table_read_current_page, table_read_last_page,
      table_read_pre_increment, table_read_last_page_pre_increment};
    logic [7:0] lows[4] = '{8'hff, 8'h07, 8'hff, 8'h41};
    logic [7:0] pages[4] = '{8'h3c, 8'hff, 8'h12, 8'hff};
    logic [7:0] nl;
    logic [7:0] v;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      nl = (i >= 2) ? lows[i] + 8'h01 : lows[i];
      w = pat({pages[i], nl});
      set_tp(lows[i], 8'h12);
      set_acc(8'h99);
      rd_seen = 0;
      run(ops[i], 8'h20 + 8'(i), 3'h0);
      check("table cycles", 16'(took), 16'h3);
      check("table addr", prog_addr, {pages[i], nl});
      check("table strobes", 16'(rd_seen), 16'h0001);
      check("table latch", 16'(table_high_latch), 16'(w[15:8]));
      check("table low ptr", 16'(table_pointer_low), 16'(nl));
      check("table high ptr", 16'(table_pointer_high), 16'h12);
      check("table acc", 16'(accumulator), 16'h99);
      read_mem(8'h20 + 8'(i), v);
      check("table byte", 16'(v), 16'(w[7:0]));
    end
  endtask

  task automatic t_xor();
    logic [7:0] v;
    wr_mem(8'h30, 8'h3c);
    set_acc(8'h3c);
    run(exclusive_or_to_accumulator, 8'h30, 3'h0);
    check("xor acc zero", {accumulator, 7'h0, zero_flag}, 16'h0001);
    set_acc(8'h0f);
    run(exclusive_or_to_accumulator, 8'h30, 3'h0);
    check("xor acc", {accumulator, 7'h0, zero_flag}, 16'h3300);
    check("xor cycles", 16'(took), 16'h1);
    wr_mem(8'h31, 8'h55);
    set_acc(8'h55);
    run(exclusive_or_to_memory, 8'h31, 3'h0);
    check("xorm flag acc", {accumulator, 7'h0, zero_flag}, 16'h5501);
    read_mem(8'h31, v);
    check("xorm byte", 16'(v), 16'h0000);
    wr_mem(8'h32, 8'h0f);
    set_acc(8'hf1);
    run(exclusive_or_to_memory, 8'h32, 3'h0);
    check("xorm flag", 16'(zero_flag), 16'h0000);
    read_mem(8'h32, v);
    check("xorm byte2", 16'(v), 16'h00fe);
  endtask

  initial begin
    sys_rst = 1'b1;
    issue = 1'b0;
    op = skip_if_zero_copy_to_acc;
    mem_addr = 8'h00;
    bit_sel = 3'h0;
    pc_page = 8'h3c;
    prog_word = 16'h0000;
    acc_load = 1'b0;
    acc_in = 8'h00;
    tp_load = 1'b0;
    tp_low_in = 8'h00;
    tp_high_in = 8'h00;
    ext_wr = 1'b0;
    ext_addr = 8'h00;
    ext_wdata = 8'h00;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("ready after reset", 16'(ready), 16'h0001);
    t_copy_skip();
    t_bit_test();
    t_table();
    t_xor();
    final_report();
  end
endmodule
